// ===== design/ascg_afe_end.sv
// front-end end of the cascade link: 16-bit word stage with gain and input-mux control
// assumes serial pins run on link_clk; enable and reset arrive from the host's retiming flops
`timescale 1ns/1ps
module ascg_afe_end (
	// link
	ascg_link_if.afe link,
	// control
	input wire logic clk_en,
	input wire logic rstn,
	// converters
	input wire logic [15:0] adc_word_a,
	input wire logic [15:0] adc_word_b,
	output logic [10:0] dac_word_a,
	output logic [10:0] dac_word_b,
	// analog input setup
	output logic [2:0] input_gain_select,
	output logic preamp_on,
	output logic single_ended_on,
	output logic input_polarity_swap,
	output logic route_negative_pin
);
	logic en_meta;
	logic en_sync;
	logic rst_meta;
	logic rst_sync;
	logic live;
	logic in_active;
	logic [3:0] in_cnt;
	logic [15:0] in_sr;
	logic word_done;
	logic [15:0] word;
	logic take;
	logic [15:0] next_out_word;
	logic [15:0] out_sr;
	logic [3:0] out_left;

	// two-stage synchronisers for the retimed enable and reset
	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			en_meta <= 1'b0;
			en_sync <= 1'b0;
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else if (clk_en) begin
			en_meta <= link.port_power_enable;
			en_sync <= en_meta;
			rst_meta <= link.afe_reset_n;
			rst_sync <= rst_meta;
		end
	end

	assign live = en_sync && rst_sync;
	assign word_done = in_active && !link.in_frame_sync && (in_cnt == ascg_pkg::LAST_BIT_COUNT);
	assign word = {in_sr[14:0], link.serial_data_in};
	assign take = word_done && (word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] == ascg_pkg::HOP_HERE);

	// frame sync marks the first bit; a new sync realigns
	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			in_active <= 1'b0;
			in_cnt <= 4'h0;
			in_sr <= 16'h0000;
		end else if (clk_en) begin
			if (!live) begin
				in_active <= 1'b0;
				in_cnt <= 4'h0;
			end else if (link.in_frame_sync) begin
				in_active <= 1'b1;
				in_cnt <= ascg_pkg::FIRST_BIT_COUNT;
				in_sr <= word;
			end else if (in_active) begin
				in_sr <= word;
				in_cnt <= in_cnt + 4'h1;
				if (in_cnt == ascg_pkg::LAST_BIT_COUNT) begin
					in_active <= 1'b0;
				end
			end
		end
	end

	// words for later devices lose one hop; own word is answered and marked consumed
	always_comb begin
		next_out_word = word;
		if (word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] == ascg_pkg::HOP_CONSUMED) begin
			next_out_word = word;
		end else if (!take) begin
			next_out_word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] = word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] - 3'h1;
		end else if (word[ascg_pkg::CTRL_BIT]) begin
			next_out_word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] = ascg_pkg::HOP_CONSUMED;
		end else begin
			next_out_word[ascg_pkg::HOP_MSB:ascg_pkg::HOP_LSB] = ascg_pkg::HOP_CONSUMED;
			next_out_word[ascg_pkg::SAMPLE_MSB:0] = word[ascg_pkg::CHAN_BIT] ?
				adc_word_b[15:ascg_pkg::ADC_KEEP_LSB] : adc_word_a[15:ascg_pkg::ADC_KEEP_LSB];
		end
	end

	// output stage: processed word leaves one bit per clock, its first bit in the same cycle as its own sync
	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			out_sr <= 16'h0000;
			out_left <= 4'h0;
			link.serial_data_out <= 1'b0;
			link.out_frame_sync <= 1'b0;
		end else if (clk_en) begin
			if (live && word_done) begin
				link.out_frame_sync <= 1'b1;
				link.serial_data_out <= next_out_word[15];
				out_sr <= {next_out_word[14:0], 1'b0};
				out_left <= ascg_pkg::BITS_AFTER_FIRST;
			end else if (live && out_left != 4'h0) begin
				link.out_frame_sync <= 1'b0;
				link.serial_data_out <= out_sr[15];
				out_sr <= {out_sr[14:0], 1'b0};
				out_left <= out_left - 4'h1;
			end else begin
				link.out_frame_sync <= 1'b0;
				link.serial_data_out <= 1'b0;
				out_left <= 4'h0;
			end
		end
	end

	// control words and dac samples addressed here
	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			input_gain_select <= ascg_pkg::GAIN_RESET;
			preamp_on <= 1'b0;
			single_ended_on <= 1'b0;
			input_polarity_swap <= 1'b0;
			route_negative_pin <= 1'b0;
			dac_word_a <= 11'h000;
			dac_word_b <= 11'h000;
		end else if (clk_en) begin
			if (!rst_sync) begin
				input_gain_select <= ascg_pkg::GAIN_RESET;
				preamp_on <= 1'b0;
				single_ended_on <= 1'b0;
				input_polarity_swap <= 1'b0;
				route_negative_pin <= 1'b0;
			end else if (live && take && word[ascg_pkg::CTRL_BIT]) begin
				if (word[ascg_pkg::SEL_MSB:ascg_pkg::SEL_LSB] == ascg_pkg::SEL_CONTROL_REG_D) begin
					input_gain_select <= word[ascg_pkg::GAIN_MSB:0];
					preamp_on <= (word[ascg_pkg::GAIN_MSB:0] >= ascg_pkg::GAIN_PREAMP_MIN);
				end
				if (word[ascg_pkg::SEL_MSB:ascg_pkg::SEL_LSB] == ascg_pkg::SEL_CONTROL_REG_F) begin
					single_ended_on <= word[ascg_pkg::SE_ON_BIT];
					input_polarity_swap <= word[ascg_pkg::POL_SWAP_BIT];
					route_negative_pin <= word[ascg_pkg::SE_ON_BIT] && word[ascg_pkg::POL_SWAP_BIT];
				end
			end else if (live && take) begin
				if (word[ascg_pkg::CHAN_BIT]) begin
					dac_word_b <= word[ascg_pkg::SAMPLE_MSB:0];
				end else begin
					dac_word_a <= word[ascg_pkg::SAMPLE_MSB:0];
				end
			end
		end
	end
endmodule

// ===== design/ascg_host_end.sv
// host end of the cascade link: AXI4-Lite registers, serial transmit/receive, enable/reset retiming
// assumes core_clk at 40 MHz, a free-running link_clk and afe_master_clock from the bench
// Notes on behaviour
// - host port pins pair with front-end pins
// - port enable driven from a register flag
// - soft reset bit keeps front end resettable
// - cascade carries up to six extra channels
// - enable and reset retimed by one flop
// - each device output feeds the next input
// - host receives only from the last device
// - one shared bit clock serves the chain
// - gain select field sets the preamplifier
// - control register F selects single-ended mode
// - single-ended mode routes positive or negative pin
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module ascg_host_end (
	// clocks and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// link
	ascg_link_if.host link
);
	// core domain: registers, bus handshake and crossing flops
	logic ctrl_power, ctrl_run, tx_req, ack_meta, ack_sync, tx_busy, rx_valid;
	logic rxt_meta, rxt_sync, rxt_single_ended_on, rx_new, aw_got, w_got, wr_fire, ar_fire;
	logic next_aw_got, next_w_got, next_rvalid;
	logic [15:0] tx_word, rx_word;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [2:0] wr_dec, rd_dec;
	// master clock domain
	logic pwr_meta, pwr_mid, run_meta, run_mid;
	// link domain
	logic req_meta, req_sync, req_single_ended_on, tx_ack, rx_active, rx_tgl, rx_done;
	ascg_pkg::ascg_tx_state_type tx_state;
	logic [15:0] tx_sr, rx_sr, rx_hold;
	logic [3:0] tx_left, rx_cnt;

	// address decode: {mapped, index}
	function automatic logic [2:0] ascg_decode(input logic [7:0] addr);
		case (addr)
			ascg_pkg::OFS_CTRL: ascg_decode = 3'h4;
			ascg_pkg::OFS_TX_WORD: ascg_decode = 3'h5;
			ascg_pkg::OFS_RX_WORD: ascg_decode = 3'h6;
			ascg_pkg::OFS_STATUS: ascg_decode = 3'h7;
			default: ascg_decode = 3'h0;
		endcase
	endfunction

	assign wr_dec = ascg_decode(wa);
	assign rd_dec = ascg_decode(araddr);
	assign wr_fire = aw_got && w_got && !bvalid;
	assign ar_fire = arvalid && arready;
	assign tx_busy = (tx_req != ack_sync);
	assign rx_new = (rxt_sync != rxt_single_ended_on);

	always_comb begin
		next_aw_got = (aw_got && !wr_fire) || (awvalid && awready);
		next_w_got = (w_got && !wr_fire) || (wvalid && wready);
		next_rvalid = (rvalid && !rready) || ar_fire;
	end

	// axi handshakes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= ascg_pkg::RESP_OKAY;
			wa <= 8'h00;
			wd <= 32'h00000000;
			ws <= 4'h0;
		end else if (clk_en) begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			awready <= !next_aw_got;
			wready <= !next_w_got;
			if (awvalid && awready) begin
				wa <= awaddr;
			end
			if (wvalid && wready) begin
				wd <= wdata;
				ws <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_dec[2] ? ascg_pkg::RESP_OKAY : ascg_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// register writes; a new transmit word is refused while one is in flight
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_power <= 1'b0;
			ctrl_run <= 1'b0;
			tx_word <= 16'h0000;
			tx_req <= 1'b0;
		end else if (clk_en && wr_fire && ws[0]) begin
			if (wr_dec == 3'h4) begin
				ctrl_power <= wd[ascg_pkg::CTRL_POWER_BIT];
				ctrl_run <= wd[ascg_pkg::CTRL_RUN_BIT];
			end else if (wr_dec == 3'h5 && !tx_busy && ws[1]) begin
				tx_word <= wd[15:0];
				tx_req <= !tx_req;
			end
		end
	end

	// reads; reading the receive word clears its valid flag, a new word wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			arready <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= ascg_pkg::RESP_OKAY;
			rx_valid <= 1'b0;
			rx_word <= 16'h0000;
		end else if (clk_en) begin
			rvalid <= next_rvalid;
			arready <= !next_rvalid;
			if (ar_fire) begin
				rresp <= rd_dec[2] ? ascg_pkg::RESP_OKAY : ascg_pkg::RESP_SLVERR;
				case (rd_dec)
					3'h4: rdata <= {30'h00000000, ctrl_run, ctrl_power};
					3'h5: rdata <= {16'h0000, tx_word};
					3'h6: rdata <= {16'h0000, rx_word};
					3'h7: rdata <= {30'h00000000, rx_valid, tx_busy};
					default: rdata <= 32'h00000000;
				endcase
			end
			if (rx_new) begin
				rx_word <= rx_hold;
				rx_valid <= 1'b1;
			end else if (ar_fire && rd_dec == 3'h6) begin
				rx_valid <= 1'b0;
			end
		end
	end

	// event toggles from the link domain
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			rxt_meta <= 1'b0;
			rxt_sync <= 1'b0;
			rxt_single_ended_on <= 1'b0;
		end else if (clk_en) begin
			ack_meta <= tx_ack;
			ack_sync <= ack_meta;
			rxt_meta <= rx_tgl;
			rxt_sync <= rxt_meta;
			rxt_single_ended_on <= rxt_sync;
		end
	end

	// enable and reset: two stages against metastability, then one shared retiming flop
	always_ff @(posedge link.afe_master_clock or negedge rstn) begin
		if (!rstn) begin
			pwr_meta <= 1'b0;
			pwr_mid <= 1'b0;
			run_meta <= 1'b0;
			run_mid <= 1'b0;
			link.port_power_enable <= 1'b0;
			link.afe_reset_n <= 1'b0;
		end else if (clk_en) begin
			pwr_meta <= ctrl_power;
			pwr_mid <= pwr_meta;
			run_meta <= ctrl_run;
			run_mid <= run_meta;
			link.port_power_enable <= pwr_mid;
			link.afe_reset_n <= run_mid;
		end
	end

	// transmit to the first device of the chain
	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_single_ended_on <= 1'b0;
			tx_ack <= 1'b0;
			tx_state <= ascg_pkg::TX_IDLE;
			tx_sr <= 16'h0000;
			tx_left <= 4'h0;
			link.serial_data_in <= 1'b0;
			link.in_frame_sync <= 1'b0;
		end else if (clk_en) begin
			req_meta <= tx_req;
			req_sync <= req_meta;
			case (tx_state)
				ascg_pkg::TX_IDLE: begin
					link.serial_data_in <= 1'b0;
					link.in_frame_sync <= 1'b0;
					if (req_sync != req_single_ended_on) begin
						req_single_ended_on <= req_sync;
						link.in_frame_sync <= 1'b1;
						link.serial_data_in <= tx_word[15];
						tx_sr <= {tx_word[14:0], 1'b0};
						tx_left <= ascg_pkg::BITS_AFTER_FIRST;
						tx_state <= ascg_pkg::TX_SHIFT;
					end
				end
				ascg_pkg::TX_SHIFT: begin
					link.in_frame_sync <= 1'b0;
					if (tx_left == 4'h0) begin
						link.serial_data_in <= 1'b0;
						tx_ack <= req_single_ended_on;
						tx_state <= ascg_pkg::TX_IDLE;
					end else begin
						link.serial_data_in <= tx_sr[15];
						tx_sr <= {tx_sr[14:0], 1'b0};
						tx_left <= tx_left - 4'h1;
					end
				end
				default: tx_state <= ascg_pkg::TX_IDLE;
			endcase
		end
	end

	// receive from the last device, on the one shared bit clock
	assign rx_done = rx_active && !link.out_frame_sync && (rx_cnt == ascg_pkg::LAST_BIT_COUNT);

	always_ff @(posedge link.link_clk or negedge rstn) begin
		if (!rstn) begin
			rx_active <= 1'b0;
			rx_cnt <= 4'h0;
			rx_sr <= 16'h0000;
			rx_hold <= 16'h0000;
			rx_tgl <= 1'b0;
		end else if (clk_en) begin
			if (link.out_frame_sync) begin
				rx_active <= 1'b1;
				rx_cnt <= ascg_pkg::FIRST_BIT_COUNT;
				rx_sr <= {rx_sr[14:0], link.serial_data_out};
			end else if (rx_active) begin
				rx_sr <= {rx_sr[14:0], link.serial_data_out};
				rx_cnt <= rx_cnt + 4'h1;
				if (rx_done) begin
					rx_active <= 1'b0;
					rx_hold <= {rx_sr[14:0], link.serial_data_out};
					rx_tgl <= !rx_tgl;
				end
			end
		end
	end
endmodule

// ===== design/ascg_link_if.sv
// link between the host serial port and a front end of the cascade
// assumes the bench drives link_clk and the master clock; chaining is done by the bench
`timescale 1ns/1ps
interface ascg_link_if;
	logic link_clk;
	logic afe_master_clock;
	logic serial_data_in;
	logic in_frame_sync;
	logic serial_data_out;
	logic out_frame_sync;
	logic port_power_enable;
	logic afe_reset_n;

	modport afe (
		input link_clk,
		input serial_data_in,
		input in_frame_sync,
		input port_power_enable,
		input afe_reset_n,
		output serial_data_out,
		output out_frame_sync
	);

	modport host (
		input link_clk,
		input afe_master_clock,
		input serial_data_out,
		input out_frame_sync,
		output serial_data_in,
		output in_frame_sync,
		output port_power_enable,
		output afe_reset_n
	);
endinterface

// ===== design/ascg_pkg.sv
// constants, word layout and state types shared by both ends of the cascade link
// assumes one shared link clock for every device and the host serial port
package ascg_pkg;
	// serial word and cascade size
	localparam int WORD_BITS = 16;
	localparam int BUILTIN_CHANNELS = 2;
	localparam int EXTRA_CHANNELS_MAX = 6;
	localparam int MAX_DEVICES = 7;
	localparam logic [3:0] LAST_BIT_COUNT = 4'hF;
	localparam logic [3:0] FIRST_BIT_COUNT = 4'h1;
	localparam logic [3:0] BITS_AFTER_FIRST = 4'hF;

	// word fields
	localparam int CTRL_BIT = 15;
	localparam int HOP_MSB = 14;
	localparam int HOP_LSB = 12;
	localparam int CHAN_BIT = 11;
	localparam int SAMPLE_MSB = 10;
	localparam int SEL_MSB = 11;
	localparam int SEL_LSB = 8;
	localparam int VALUE_MSB = 7;
	localparam int ADC_KEEP_LSB = 5;
	localparam logic [2:0] HOP_HERE = 3'h0;
	localparam logic [2:0] HOP_CONSUMED = 3'h7;

	// front-end control registers reached through control words
	localparam logic [3:0] SEL_CONTROL_REG_D = 4'hD;
	localparam logic [3:0] SEL_CONTROL_REG_F = 4'hF;
	localparam int GAIN_MSB = 2;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [2:0] GAIN_PREAMP_MIN = 3'h4;
	localparam int SE_ON_BIT = 0;
	localparam int POL_SWAP_BIT = 1;

	// host register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX_WORD = 8'h04;
	localparam logic [7:0] OFS_RX_WORD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam int CTRL_POWER_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int ST_TX_BUSY_BIT = 0;
	localparam int ST_RX_VALID_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {TX_IDLE, TX_SHIFT} ascg_tx_state_type;
endpackage

// ===== sim/ascg_link_chk.sv
// checker on the link pins between host end and front end
// assumes free-running link_clk and afe_master_clock and one shared rstn
`timescale 1ns/1ps
module ascg_link_chk (
	// clocks and reset
	input wire logic link_clk,
	input wire logic afe_master_clock,
	input wire logic rstn,
	// serial pins
	input wire logic serial_data_in,
	input wire logic in_frame_sync,
	input wire logic serial_data_out,
	input wire logic out_frame_sync,
	// retimed controls
	input wire logic port_power_enable,
	input wire logic afe_reset_n
);
	logic [3:0] cnt_in;
	logic [3:0] cnt_out;
	logic pe_neg;
	logic rn_neg;
	// bit position inside the current word, 0 when idle
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) cnt_in <= 4'h0;
		else if (in_frame_sync) cnt_in <= 4'h1;
		else if (cnt_in != 4'h0) cnt_in <= cnt_in + 4'h1;
	end
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) cnt_out <= 4'h0;
		else if (out_frame_sync) cnt_out <= 4'h1;
		else if (cnt_out != 4'h0) cnt_out <= cnt_out + 4'h1;
	end
	// pin levels in the low half of the master clock
	always_ff @(negedge afe_master_clock or negedge rstn) begin
		if (!rstn) begin
			pe_neg <= 1'b0;
			rn_neg <= 1'b0;
		end else begin
			pe_neg <= port_power_enable;
			rn_neg <= afe_reset_n;
		end
	end

	AST_IN_IDLE: assert property (@(posedge link_clk) disable iff (!rstn)
		(cnt_in == 4'h0 && !in_frame_sync) |-> !serial_data_in) else $error("data in active outside a frame");
	AST_IN_NO_RESYNC: assert property (@(posedge link_clk) disable iff (!rstn)
		in_frame_sync |-> cnt_in == 4'h0) else $error("input sync inside a word");
	AST_IN_GAP: assert property (@(posedge link_clk) disable iff (!rstn)
		in_frame_sync |=> !in_frame_sync [*8] ##1 !in_frame_sync [*7]) else $error("input frames too close");
	AST_OUT_IDLE: assert property (@(posedge link_clk) disable iff (!rstn)
		(cnt_out == 4'h0 && !out_frame_sync) |-> !serial_data_out) else $error("data out active outside a frame");
	AST_OUT_NO_RESYNC: assert property (@(posedge link_clk) disable iff (!rstn)
		out_frame_sync |-> cnt_out == 4'h0) else $error("output sync inside a word");
	AST_ANSWER: assert property (@(posedge link_clk) disable iff (!rstn)
		(in_frame_sync && port_power_enable && afe_reset_n && $past(port_power_enable, 3) && $past(afe_reset_n, 3))
		|-> ##16 out_frame_sync) else $error("device word not forwarded after 16 cycles");
	AST_OUT_CAUSED: assert property (@(posedge link_clk) disable iff (!rstn)
		out_frame_sync |-> $past(in_frame_sync, 16)) else $error("output frame without input frame");
	AST_RETIME: assert property (@(posedge afe_master_clock) disable iff (!rstn)
		port_power_enable == pe_neg && afe_reset_n == rn_neg) else $error("control pins change off master rising edge");

	COV_FRAME: cover property (@(posedge link_clk) disable iff (!rstn) in_frame_sync ##16 out_frame_sync);
	COV_POWER: cover property (@(posedge afe_master_clock) disable iff (!rstn) $rose(port_power_enable));
	COV_SOFT_RESET: cover property (@(posedge afe_master_clock) disable iff (!rstn) $fell(afe_reset_n));
endmodule

// ===== sim/tb.sv
// bench: host end and one front end joined by the link, driven over axi4-lite
// assumes the bench makes core, link and master clocks and the shared reset
`timescale 1ns/1ps
module tb;
	logic core_clk;
	logic rstn;
	logic en;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr;
	logic [7:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] resp;
	logic [15:0] adc_a;
	logic [15:0] adc_b;
	logic [10:0] dac_a;
	logic [10:0] dac_b;
	logic [2:0] gain;
	logic preamp, se_on, pol_swap, neg_pin;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	ascg_link_if lk ();
	ascg_host_end ascg_host_end_i (.core_clk(core_clk), .rstn(rstn), .clk_en(en),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .link(lk.host));
	ascg_afe_end ascg_afe_end_i (.link(lk.afe), .clk_en(en), .rstn(rstn), .adc_word_a(adc_a),
		.adc_word_b(adc_b), .dac_word_a(dac_a), .dac_word_b(dac_b), .input_gain_select(gain),
		.preamp_on(preamp), .single_ended_on(se_on), .input_polarity_swap(pol_swap),
		.route_negative_pin(neg_pin));
	ascg_link_chk ascg_link_chk_i (.link_clk(lk.link_clk), .afe_master_clock(lk.afe_master_clock),
		.rstn(rstn), .serial_data_in(lk.serial_data_in), .in_frame_sync(lk.in_frame_sync),
		.serial_data_out(lk.serial_data_out), .out_frame_sync(lk.out_frame_sync),
		.port_power_enable(lk.port_power_enable), .afe_reset_n(lk.afe_reset_n));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		lk.link_clk = 1'b0;
		#7;
		forever #32 lk.link_clk = ~lk.link_clk;
	end
	initial begin
		lk.afe_master_clock = 1'b0;
		#3;
		forever #30.5 lk.afe_master_clock = ~lk.afe_master_clock;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			results();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// control word; back selects the hop count seen on return
	function automatic logic [15:0] ctl(input logic back, input logic isf, input logic [7:0] v);
		return {1'b1, back ? ascg_pkg::HOP_CONSUMED : ascg_pkg::HOP_HERE,
			isf ? ascg_pkg::SEL_CONTROL_REG_F : ascg_pkg::SEL_CONTROL_REG_D, v};
	endfunction

	// send one word, wait for the chain end to return one, compare it
	task automatic xfer(input logic [15:0] tx, input logic [15:0] exp);
		int n;
		n = 0;
		axi_write(ascg_pkg::OFS_TX_WORD, {16'h0000, tx}, resp);
		rd = 32'h0;
		while (rd[ascg_pkg::ST_RX_VALID_BIT] !== 1'b1 && n < 100) begin
			axi_read(ascg_pkg::OFS_STATUS, rd, resp);
			n++;
		end
		axi_read(ascg_pkg::OFS_RX_WORD, rd, resp);
		check(rd, {16'h0000, exp}, "returned word");
	endtask

	initial begin
		rstn = 1'b0;
		en = 1'b1;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		adc_a = 16'hA5C3;
		adc_b = 16'h3C5A;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		axi_write(ascg_pkg::OFS_CTRL, 32'h3, resp);
		check({30'h0, resp}, {30'h0, ascg_pkg::RESP_OKAY}, "ctrl write");
		repeat (40) @(posedge core_clk);
		check({30'h0, lk.port_power_enable, lk.afe_reset_n}, 32'h3, "enable pins");
		for (int g = 0; g < 8; g++) begin
			xfer(ctl(1'b0, 1'b0, 8'(g)), ctl(1'b1, 1'b0, 8'(g)));
			check({29'h0, gain}, 32'(g), "gain select");
			check({31'h0, preamp}, {31'h0, 3'(g) >= ascg_pkg::GAIN_PREAMP_MIN}, "preamp");
		end
		for (int v = 0; v < 4; v++) begin
			xfer(ctl(1'b0, 1'b1, 8'(v)), ctl(1'b1, 1'b1, 8'(v)));
			check({29'h0, se_on, pol_swap, neg_pin}, {29'h0, v[0], v[1], v[0] & v[1]}, "input mode");
		end
		xfer({4'h0, 1'b0, 11'h155}, {1'b0, ascg_pkg::HOP_CONSUMED, 1'b0, adc_a[15:5]});
		check({21'h0, dac_a}, 32'h155, "dac a");
		xfer({4'h0, 1'b1, 11'h2AA}, {1'b0, ascg_pkg::HOP_CONSUMED, 1'b1, adc_b[15:5]});
		check({21'h0, dac_b}, 32'h2AA, "dac b");
		for (int h = 1; h < 8; h++) begin
			xfer({1'b0, 3'(h), 1'b1, 11'h0F0}, {1'b0, (h == 7) ? 3'h7 : 3'(h - 1), 1'b1, 11'h0F0});
			check({21'h0, dac_b}, 32'h2AA, "passed word kept");
		end
		axi_read(8'h10, rd, resp);
		check(rd, 32'h0, "unmapped read data");
		check({30'h0, resp}, {30'h0, ascg_pkg::RESP_SLVERR}, "unmapped read resp");
		axi_write(8'h10, 32'h0, resp);
		check({30'h0, resp}, {30'h0, ascg_pkg::RESP_SLVERR}, "unmapped write resp");
		axi_read(ascg_pkg::OFS_CTRL, rd, resp);
		check(rd, 32'h3, "ctrl readback");
		axi_write(ascg_pkg::OFS_TX_WORD, {16'h0, ctl(1'b0, 1'b0, 8'h05)}, resp);
		xfer(ctl(1'b0, 1'b0, 8'h02), ctl(1'b1, 1'b0, 8'h05));
		check({29'h0, gain}, 32'h5, "busy write ignored");
		repeat (150) @(posedge core_clk);
		axi_read(ascg_pkg::OFS_STATUS, rd, resp);
		check(rd, 32'h0, "status idle");
		axi_write(ascg_pkg::OFS_CTRL, 32'h1, resp);
		repeat (40) @(posedge core_clk);
		check({30'h0, lk.port_power_enable, lk.afe_reset_n}, 32'h2, "soft reset pins");
		check({29'h0, gain}, {29'h0, ascg_pkg::GAIN_RESET}, "gain after soft reset");
		check({30'h0, se_on, pol_swap}, 32'h0, "mode after soft reset");
		axi_write(ascg_pkg::OFS_CTRL, 32'h0, resp);
		repeat (40) @(posedge core_clk);
		check({31'h0, lk.port_power_enable}, 32'h0, "power pin off");
		axi_write(ascg_pkg::OFS_TX_WORD, {16'h0, 4'h0, 1'b0, 11'h011}, resp);
		repeat (200) @(posedge core_clk);
		axi_read(ascg_pkg::OFS_STATUS, rd, resp);
		check({31'h0, rd[ascg_pkg::ST_RX_VALID_BIT]}, 32'h0, "no word while off");
		check({21'h0, dac_a}, 32'h155, "dac kept while off");
		axi_write(ascg_pkg::OFS_CTRL, 32'h3, resp);
		repeat (40) @(posedge core_clk);
		xfer(ctl(1'b0, 1'b0, 8'h06), ctl(1'b1, 1'b0, 8'h06));
		check({29'h0, gain}, 32'h6, "gain after restart");
		// clock enable low: a pending soft reset must not reach the pins or the device
		axi_write(ascg_pkg::OFS_CTRL, 32'h1, resp);
		en <= 1'b0;
		repeat (40) @(posedge core_clk);
		check({30'h0, lk.port_power_enable, lk.afe_reset_n}, 32'h3, "pins frozen");
		check({29'h0, gain}, 32'h6, "gain frozen");
		en <= 1'b1;
		repeat (40) @(posedge core_clk);
		check({30'h0, lk.port_power_enable, lk.afe_reset_n}, 32'h2, "pins after unfreeze");
		check({29'h0, gain}, {29'h0, ascg_pkg::GAIN_RESET}, "gain after unfreeze");
		results();
	end
endmodule
